// file: logic/ota_pkg.sv
// Functional notes
// - Reset selects plain output, comparator mode
// - Assert alert when temperature exceeds upper limit
// - Comparator mode: deassert below hysteresis limit
// - Comparator mode: shutdown keeps alert state
// - Interrupt mode: any register read clears alert
// - Interrupt mode: re-arm on falling below hysteresis
// - After low event, next assert needs upper crossing
// - Interrupt mode: entering shutdown clears alert
// - Alert-pin role: answered response query clears alert
// - Config bit D7 enables alert-line role in interrupt mode
// - Alert pin is open drain only
// - Nobody uses response address as own
// - Alerting device acknowledges, returns own address
// - Returned LSB shows which limit was crossed
// - Lowest address wins; losers keep alert
// - Release alert after answering response query
// - Slave address is fixed nibble plus pins
package ota_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  OTA_CFG_OFF   = 8'h00; // Configuration
	localparam logic [7:0]  OTA_UPPER_OFF = 8'h04; // Upper limit
	localparam logic [7:0]  OTA_HYST_OFF  = 8'h08; // Hysteresis limit
	localparam logic [7:0]  OTA_STAT_OFF  = 8'h0c; // Alert status
	localparam logic [7:0]  OTA_TEMP_OFF  = 8'h10; // Last result

	// ==========================================================
	// Configuration fields and reset values
	localparam int          OTA_SHDN_BIT  = 0;     // Shutdown
	localparam int          OTA_INT_BIT   = 1;     // Interrupt mode
	localparam int          OTA_POL_BIT   = 2;     // Active high
	localparam int          OTA_SMBA_BIT  = 7;     // Alert-line role
	localparam logic [7:0]  OTA_CFG_RST   = 8'h00;
	localparam logic [15:0] OTA_UPPER_RST = 16'h5000;
	localparam logic [15:0] OTA_HYST_RST  = 16'h4b00;

	// ==========================================================
	// Serial bus constants
	localparam logic [6:0]  OTA_ARA_ADDR  = 7'h0c; // Response address
	localparam logic [3:0]  OTA_ADDR_HI   = 4'h9;  // Fixed upper nibble
	localparam logic [2:0]  OTA_LAST_BIT  = 3'h7;  // Index of the last bit of a byte

	// Conditioned link events as one-cycle pulses, plus data and address pin levels
	typedef struct packed {
		logic       scl_rise;
		logic       scl_fall;
		logic       start;
		logic       stop;
		logic       sda;
		logic [2:0] addr_pins;
	} ota_link_t;

	// Response-query engine states
	typedef enum logic [2:0] {
		ARA_IDLE  = 3'b000,
		ARA_ADDR  = 3'b001,
		ARA_CHECK = 3'b010,
		ARA_ACK   = 3'b011,
		ARA_SEND  = 3'b100,
		ARA_DONE  = 3'b101
	} ota_ara_st_t;

endpackage

// file: logic/ota_link_front.sv
`timescale 1ns/10ps
module ota_link_front
	import ota_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [2:0] addr_pins,
	output ota_link_t       link
);

	// ==========================================================
	// Two-stage synchronisers for every pin
	logic [4:0] meta_q;   // First stage, read only by stage two
	logic [4:0] sync_q;   // Second stage
	logic       scl_d1_q; // Previous clock level
	logic       sda_d1_q; // Previous data level

	// Sample pins; idle bus reads high
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q <= 5'h03;
			sync_q <= 5'h03;
		end else begin
			meta_q <= {addr_pins, sda_i, scl_i};
			sync_q <= meta_q;
		end
	end

	// Delayed copies for edge finding
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= sync_q[0];
			sda_d1_q <= sync_q[1];
		end
	end

	// ==========================================================
	// Edges and bus conditions
	// Start and stop need the clock high in both samples
	wire scl_hi = sync_q[0] & scl_d1_q;

	assign link.scl_rise  = sync_q[0] & ~scl_d1_q;
	assign link.scl_fall  = ~sync_q[0] & scl_d1_q;
	assign link.start     = scl_hi & sda_d1_q & ~sync_q[1];
	assign link.stop      = scl_hi & ~sda_d1_q & sync_q[1];
	assign link.sda       = sync_q[1];
	assign link.addr_pins = sync_q[4:2];

endmodule

// file: logic/ota_alert_top.sv
`timescale 1ns/10ps
module ota_alert_top
	import ota_pkg::*;
#(
	parameter int TEMP_W = 16 // Width of a conversion result
)(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [TEMP_W-1:0] temp_data,
	input  wire logic              temp_valid,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	input  wire logic [2:0]        addr_pins,
	output logic                   overtemp_alert_pin_o,
	output logic                   overtemp_alert_pin_oe,
	output logic                   shutdown_o
);

	// ==========================================================
	// Elaboration check
	// Limits are kept in 16-bit registers
	if (TEMP_W < 2 || TEMP_W > 16) begin : g_bad_w
		$error("TEMP_W must lie between 2 and 16");
	end

	// ==========================================================
	// Helpers
	// Signed compare of a result against a limit
	function automatic logic ota_gt(
		input logic [TEMP_W-1:0] a,
		input logic [TEMP_W-1:0] b
	);
		ota_gt = $signed(a) > $signed(b);
	endfunction

	// Zero-extend a 16-bit field onto the data bus
	function automatic logic [31:0] ota_word(input logic [15:0] v);
		ota_word = {16'h0000, v};
	endfunction

	// ==========================================================
	// Declarations
	logic [7:0]        cfg_q;       // Configuration register
	logic [15:0]       upper_q;     // Upper temperature limit
	logic [15:0]       hyst_q;      // Hysteresis temperature limit
	logic [TEMP_W-1:0] temp_q;      // Last conversion result
	logic              active_q;    // Overtemp output, logical
	logic              active_d;
	logic              arm_low_q;   // Interrupt mode waits low
	logic              arm_low_d;
	logic              flag_q;      // Which limit was crossed
	logic              shdn_d1_q;   // Shutdown, previous cycle
	ota_link_t         link;        // Conditioned link events
	ota_ara_st_t       st_q;        // Response-query state
	ota_ara_st_t       st_d;
	logic [2:0]        cnt_q;       // Bit counter
	logic [2:0]        cnt_d;
	logic [7:0]        sh_q;        // Address / reply shifter
	logic [7:0]        sh_d;
	logic              pull_q;      // Pull data line low
	logic              pull_d;
	logic              ara_ok;      // Reply finished cleanly

	// ==========================================================
	// Link front end
	ota_link_front u_front (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.addr_pins (addr_pins),
		.link      (link)
	);

	// ==========================================================
	// Register bus decode
	wire setup_ph  = psel & ~penable;
	wire acc_done  = psel & penable & pready;
	wire wr_fire   = acc_done & pwrite;
	wire rd_fire   = acc_done & ~pwrite;
	wire hit_cfg   = paddr == OTA_CFG_OFF;
	wire hit_upper = paddr == OTA_UPPER_OFF;
	wire hit_hyst  = paddr == OTA_HYST_OFF;
	wire hit_stat  = paddr == OTA_STAT_OFF;
	wire hit_temp  = paddr == OTA_TEMP_OFF;
	wire hit_any   = hit_cfg | hit_upper | hit_hyst | hit_stat
	               | hit_temp;
	// A mapped read stands in for a serial register read
	wire reg_read  = rd_fire & hit_any;

	// Configuration fields
	wire shdn    = cfg_q[OTA_SHDN_BIT];
	wire intmode = cfg_q[OTA_INT_BIT];
	wire pol_hi  = cfg_q[OTA_POL_BIT];
	wire smba_en = cfg_q[OTA_SMBA_BIT];

	// Read data mux, selected in the setup cycle
	wire [31:0] stat_word = {29'h0, arm_low_q, flag_q, active_q};
	wire [15:0] temp_ext  = 16'(temp_q);
	wire [31:0] rd_mux    =
		hit_cfg   ? {24'h0, cfg_q}     :
		hit_upper ? ota_word(upper_q)  :
		hit_hyst  ? ota_word(hyst_q)   :
		hit_stat  ? stat_word          :
		hit_temp  ? ota_word(temp_ext) : 32'h0;

	// Answer one cycle after setup; no wait states
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			prdata  <= setup_ph ? rd_mux : prdata;
			pslverr <= setup_ph & ~hit_any;
		end
	end

	// ==========================================================
	// Writable registers
	// Reset gives plain output, comparator mode, running
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_q   <= OTA_CFG_RST;
			upper_q <= OTA_UPPER_RST;
			hyst_q  <= OTA_HYST_RST;
		end else if (wr_fire) begin
			// Bit D7 chooses the alert-line role
			if (hit_cfg)   cfg_q   <= pwdata[7:0];
			if (hit_upper) upper_q <= pwdata[15:0];
			if (hit_hyst)  hyst_q  <= pwdata[15:0];
		end
	end

	// ==========================================================
	// Limit comparison
	// Limits are cut to the result width, high bits kept
	wire [TEMP_W-1:0] upper_lim = upper_q[15 -: TEMP_W];
	wire [TEMP_W-1:0] hyst_lim  = hyst_q[15 -: TEMP_W];
	// Conversions halt in shutdown, so results are ignored
	wire new_res  = temp_valid & ~shdn;
	wire above    = ota_gt(temp_data, upper_lim);
	wire below    = ota_gt(hyst_lim, temp_data);
	wire at_upper = ~ota_gt(upper_lim, temp_data);
	wire shdn_ent = shdn & ~shdn_d1_q;

	// Events, sampled once per finished result
	wire cmp_set = new_res & above;
	wire int_hi  = new_res & ~arm_low_q & above;
	wire int_lo  = new_res & arm_low_q & below;
	wire int_set = int_hi | int_lo;

	// Keep the latest result and the crossing flag
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			temp_q    <= '0;
			flag_q    <= 1'b0;
			shdn_d1_q <= 1'b0;
		end else begin
			shdn_d1_q <= shdn;
			if (new_res) begin
				temp_q <= temp_data;
				// High at or over upper, low under hysteresis
				if (at_upper)
					flag_q <= 1'b1;
				else if (below)
					flag_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Alert state, next value
	// A new event in the clearing cycle wins over the clear
	always_comb begin
		active_d  = active_q;
		arm_low_d = arm_low_q;
		if (!intmode) begin
			// Comparator: follow the two limits only
			arm_low_d = 1'b0;
			if (cmp_set)
				active_d = 1'b1;
			else if (new_res && below)
				active_d = 1'b0;
			// Shutdown entry leaves the state alone
		end else begin
			if (reg_read)
				active_d = 1'b0;
			if (ara_ok)
				active_d = 1'b0;
			if (shdn_ent)
				active_d = 1'b0;
			if (int_hi) begin
				active_d  = 1'b1;
				arm_low_d = 1'b1;
			end else if (int_lo) begin
				active_d  = 1'b1;
				arm_low_d = 1'b0;
			end
		end
	end

	// Alert state registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			active_q  <= 1'b0;
			arm_low_q <= 1'b0;
		end else begin
			active_q  <= active_d;
			arm_low_q <= arm_low_d;
		end
	end

	// ==========================================================
	// Alert pin driver
	// Open drain: only pull low or release
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overtemp_alert_pin_o  <= 1'b0;
			overtemp_alert_pin_oe <= 1'b0;
			shutdown_o            <= 1'b0;
		end else begin
			overtemp_alert_pin_o  <= 1'b0;
			// Active low pulls when asserted, active high when not
			overtemp_alert_pin_oe <= active_d ^ pol_hi;
			shutdown_o            <= shdn;
		end
	end

	// ==========================================================
	// Response-query engine
	// Own address: fixed nibble then the three pins
	wire [6:0] own_addr = {OTA_ADDR_HI, link.addr_pins};
	// Answer only in the alert-line role and while alerting
	wire may_answer = smba_en & intmode & active_q;
	wire ara_match  = sh_q == {OTA_ARA_ADDR, 1'b1};
	// Lost when released high but the line reads low
	wire lost_arb   = ~pull_q & ~link.sda;

	// Next state of the byte engine
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		pull_d = pull_q;
		ara_ok = 1'b0;
		if (link.stop) begin
			// A stop ends any transfer
			st_d   = ARA_IDLE;
			pull_d = 1'b0;
		end else if (link.start) begin
			// Start or repeated start opens an address byte
			st_d   = ARA_ADDR;
			cnt_d  = 3'h0;
			pull_d = 1'b0;
		end else begin
			case (st_q)
				ARA_ADDR: begin
					if (link.scl_rise) begin
						sh_d  = {sh_q[6:0], link.sda};
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == OTA_LAST_BIT)
							st_d = ARA_CHECK;
					end
				end
				ARA_CHECK: begin
					if (link.scl_fall) begin
						// Acknowledge the query while alerting
						if (ara_match && may_answer) begin
							pull_d = 1'b1;
							st_d   = ARA_ACK;
						end else begin
							st_d = ARA_IDLE;
						end
					end
				end
				ARA_ACK: begin
					if (link.scl_fall) begin
						// Reply: own address, crossing flag
						sh_d   = {own_addr, flag_q};
						pull_d = ~own_addr[6];
						cnt_d  = 3'h0;
						st_d   = ARA_SEND;
					end
				end
				ARA_SEND: begin
					if (link.scl_rise && lost_arb) begin
						// Back off; alert stays up
						pull_d = 1'b0;
						st_d   = ARA_IDLE;
					end else if (link.scl_rise
					             && cnt_q == OTA_LAST_BIT) begin
						ara_ok = 1'b1;
						st_d   = ARA_DONE;
					end else if (link.scl_fall) begin
						sh_d   = {sh_q[6:0], 1'b0};
						pull_d = ~sh_q[6];
						cnt_d  = cnt_q + 3'h1;
					end
				end
				ARA_DONE: begin
					// Release for the master's not-acknowledge
					if (link.scl_fall) begin
						pull_d = 1'b0;
						st_d   = ARA_IDLE;
					end
				end
				default: begin
					pull_d = 1'b0;
					st_d   = ARA_IDLE;
				end
			endcase
		end
	end

	// Byte engine registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q   <= ARA_IDLE;
			cnt_q  <= 3'h0;
			sh_q   <= 8'h00;
			pull_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			pull_q <= pull_d;
		end
	end

	// Data line driver, open drain like the alert pin
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sda_o  <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			sda_o  <= 1'b0;
			sda_oe <= pull_d;
		end
	end

endmodule

// file: bench/ota_checker.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the alert block
module ota_checker
	import ota_pkg::*;
#(
	parameter int TEMP_W = 16 // Result width
)(
	input wire logic              clock,
	input wire logic              sys_rst,
	input wire logic [7:0]        paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [TEMP_W-1:0] temp_data,
	input wire logic              temp_valid,
	input wire logic              sda_o,
	input wire logic              sda_oe,
	input wire logic              overtemp_alert_pin_o,
	input wire logic              overtemp_alert_pin_oe,
	input wire logic              shutdown_o
);
	// ==========================================
	// Shadow of settings written over APB
	logic [7:0]        cfg_q; // Settings copy
	logic [TEMP_W-1:0] up_q;  // Upper limit copy
	logic [TEMP_W-1:0] hy_q;  // Hysteresis copy
	wire acc    = psel && penable && pready && !pslverr; // Mapped access
	wire wr_cfg = acc && pwrite && paddr == OTA_CFG_OFF;
	wire rd_any = acc && !pwrite;
	// Result with no bus access beside it to blur the cause
	wire quiet  = temp_valid && !shutdown_o && !(psel && penable);
	wire hot    = $signed(temp_data) > $signed(up_q);
	wire cold   = $signed(temp_data) < $signed(hy_q);
	wire oe     = overtemp_alert_pin_oe;
	wire irq_m  = cfg_q[OTA_INT_BIT]; // Interrupt mode
	wire act_hi = cfg_q[OTA_POL_BIT]; // Active-high polarity

	// Copies follow committed writes only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_q <= OTA_CFG_RST;
			// Limits keep their top bits, like the compare path
			up_q <= OTA_UPPER_RST[15 -: TEMP_W];
			hy_q <= OTA_HYST_RST[15 -: TEMP_W];
		end else if (acc && pwrite) begin
			if (paddr == OTA_CFG_OFF) cfg_q <= pwdata[7:0];
			if (paddr == OTA_UPPER_OFF) up_q <= pwdata[15 -: TEMP_W];
			if (paddr == OTA_HYST_OFF) hy_q <= pwdata[15 -: TEMP_W];
		end
	end

	// ==========================================
	// Assertions, one clock domain
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_pin_drive: assert property (
		!overtemp_alert_pin_o && !sda_o) else $error("pin data not low");
	a_reset_idle: assert property (
		$fell(sys_rst) |-> !oe && !sda_oe) else $error("busy after reset");
	a_cmp_set: assert property (
		quiet && !irq_m && hot |=> oe == !act_hi) else $error("no alert");
	a_cmp_clr: assert property (
		quiet && !irq_m && cold |=> oe == act_hi) else $error("alert kept");
	a_cmp_shdn: assert property (
		wr_cfg && !irq_m && pwdata[2:0] == {act_hi, 2'b01} && !temp_valid
		|=> $stable(oe)) else $error("shutdown moved alert");
	a_int_shdn: assert property (
		wr_cfg && irq_m && !cfg_q[OTA_SHDN_BIT] && !temp_valid &&
		pwdata[2:0] == {act_hi, 2'b11} |-> ##[1:2] oe == act_hi)
		else $error("shutdown kept alert");
	a_int_rdclr: assert property (
		rd_any && irq_m && !temp_valid |-> ##[1:2] oe == act_hi)
		else $error("read kept alert");
	a_shdn_hold: assert property (
		temp_valid && shutdown_o && !(psel && penable) |=> $stable(oe))
		else $error("result used in shutdown");
	a_ara_gate: assert property (
		!(cfg_q[OTA_SMBA_BIT] && irq_m) |-> !sda_oe)
		else $error("reply while role off");
	a_shdn_copy: assert property (
		shutdown_o == $past(cfg_q[OTA_SHDN_BIT]))
		else $error("shutdown copy wrong");

	// Main scenarios reached
	cover property (quiet && hot);
	cover property (rd_any && irq_m);
	cover property (sda_oe ##1 !sda_oe);
endmodule

// file: bench/ota_smb_master.sv
`timescale 1ns/10ps
// ==========================================
// Serial bus master issuing response queries
module ota_smb_master
	import ota_pkg::*;
(
	output logic      scl,    // Stands high outside frames
	output logic      sda_oe, // High pulls data low
	input  wire logic sda     // Wire level, pulled up
);
	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// One 400 ns slot; data moves mid-low to keep clear of edges
	task automatic slot(input logic b, output logic r);
		#100 sda_oe = !b;
		#100 scl = 1'b1;
		#100 r = sda;
		#100 scl = 1'b0;
	endtask

	// Start, address and read, ack, byte, nack, stop.
	// Rival byte pulls the wire as a second answering device.
	task automatic ara_read(input logic [7:0] rival,
		output logic [7:0] d, output logic ack);
		logic [7:0] a;
		logic       r;
		a = {OTA_ARA_ADDR, 1'b1};
		sda_oe = 1'b1;
		#200 scl = 1'b0;
		for (int i = 7; i >= 0; i--) slot(a[i], r);
		slot(1'b1, r);
		ack = !r;
		for (int i = 7; i >= 0; i--) slot(rival[i], d[i]);
		slot(1'b1, r); // Not acknowledged, ends the read
		#100 sda_oe = 1'b1;
		#100 scl = 1'b1;
		#100 sda_oe = 1'b0;
		#100;
	endtask
endmodule

// file: bench/ota_alert_top_tb_top.sv
`timescale 1ns/10ps
// ==========================================
// Bench: APB driver, read watcher, query master
module ota_alert_top_tb_top
	import ota_pkg::*;
;
	logic        clock, sys_rst, psel, penable, pwrite, temp_valid;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, sda_oe, pin_oe, scl, m_sda_oe;
	logic [15:0] temp_data, hot;
	logic [2:0]  p;            // Address pins, random
	logic [32:0] exp_q[$];     // Notes of {error, data} per read
	int          fail_count, checks;
	wire         sda = !(sda_oe || m_sda_oe); // Pulled-up wire
	wire         pin = !pin_oe;               // Pulled-up alert wire

	ota_alert_top i_dut (.clock, .sys_rst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .temp_data,
		.temp_valid, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe,
		.addr_pins(p), .overtemp_alert_pin_o(),
		.overtemp_alert_pin_oe(pin_oe), .shutdown_o());
	ota_smb_master i_master (.scl, .sda_oe(m_sda_oe), .sda);

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = !clock;
	end

	task automatic check(input string nm, input logic [32:0] seen,
		input logic [32:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, want, seen);
		end
	endtask

	// Watcher: each finished read against the oldest note
	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite)
			check("read", {pslverr, prdata}, exp_q.pop_front());

	// One APB transfer, held until ready is sampled
	task automatic apb(input logic [7:0] a, input logic [31:0] d,
		input logic w, input logic [32:0] e);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		if (!w) exp_q.push_back(e);
		@(posedge clock);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hang
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pin level checked once any update has landed
	task automatic pin_is(input logic want);
		repeat (2) @(posedge clock);
		#1 check("pin", 33'(pin), 33'(want));
	endtask

	// One conversion result pulse
	task automatic tsend(input logic [15:0] v, input logic want);
		@(posedge clock);
		temp_data <= v;
		temp_valid <= 1'b1;
		@(posedge clock);
		temp_valid <= 1'b0;
		pin_is(want);
	endtask

	task automatic query(input logic [7:0] rival, input logic [7:0] want,
		input logic ack_w);
		logic [7:0] d;
		logic       ack;
		// Keep the serial lines off the clock edges
		#10 i_master.ara_read(rival, d, ack);
		check("ack", 33'(ack), 33'(ack_w));
		check("reply", 33'(d), 33'(want));
	endtask

	task automatic conclude;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial begin
		{sys_rst, psel, penable, pwrite, temp_valid} = 5'h10;
		{paddr, pwdata, temp_data} = '0;
		void'($urandom(46));
		p = 3'($urandom_range(7, 1));
		hot = OTA_UPPER_RST + 16'($urandom_range(255, 1));
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		apb(OTA_CFG_OFF, 0, 0, 33'h0);
		apb(OTA_UPPER_OFF, 0, 0, {17'h0, OTA_UPPER_RST});
		apb(OTA_HYST_OFF, 0, 0, {17'h0, OTA_HYST_RST});
		apb(8'h14, 0, 0, {1'b1, 32'h0}); // Unmapped place
		pin_is(1'b1);
		$display("test 1 done");
		tsend(OTA_UPPER_RST, 1'b1);
		tsend(hot, 1'b0);
		tsend(OTA_HYST_RST, 1'b0);
		apb(OTA_CFG_OFF, 1, 1, 0);
		pin_is(1'b0);
		tsend(16'h0, 1'b0);
		apb(OTA_CFG_OFF, 4, 1, 0);
		tsend(OTA_HYST_RST - 16'h1, 1'b0);
		tsend(hot, 1'b1);
		apb(OTA_STAT_OFF, 0, 0, 33'h3);
		apb(OTA_CFG_OFF, 0, 1, 0);
		tsend(16'h0, 1'b1);
		$display("test 2 done");
		apb(OTA_CFG_OFF, 2, 1, 0);
		tsend(hot, 1'b0);
		query(8'hff, 8'hff, 1'b0);
		apb(OTA_TEMP_OFF, 0, 0, {17'h0, hot});
		pin_is(1'b1);
		tsend(hot, 1'b1);
		tsend(16'h0, 1'b0);
		apb(OTA_UPPER_OFF, 0, 0, {17'h0, OTA_UPPER_RST});
		pin_is(1'b1);
		tsend(16'h0, 1'b1);
		tsend(hot, 1'b0);
		$display("test 3 done");
		apb(OTA_CFG_OFF, 32'h82, 1, 0);
		query(8'hff, {OTA_ADDR_HI, p, 1'b1}, 1'b1);
		pin_is(1'b1);
		tsend(16'h0, 1'b0);
		query(8'h90, 8'h90, 1'b1);
		pin_is(1'b0);
		query(8'hff, {OTA_ADDR_HI, p, 1'b0}, 1'b1);
		pin_is(1'b1);
		tsend(hot, 1'b0);
		apb(OTA_CFG_OFF, 3, 1, 0);
		pin_is(1'b1);
		$display("test 4 done");
		conclude();
	end

	// Watchdog: the tests need well under 150 us
	initial begin
		#300_000;
		fail_count++;
		conclude();
	end
endmodule

bind ota_alert_top ota_checker #(.TEMP_W(TEMP_W)) i_chk (.clock,
	.sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
	.pslverr, .temp_data, .temp_valid, .sda_o, .sda_oe,
	.overtemp_alert_pin_o, .overtemp_alert_pin_oe, .shutdown_o);
